// file: shared/adcstc_defines.svh
// Offsets, field positions, reset values and timing counts of the scan/trigger/flag block.
// Assumes a byte-addressed register port with one 32-bit word per register.
`ifndef ADCSTC_DEFINES_SVH
`define ADCSTC_DEFINES_SVH

`define ADCSTC_GROUPS        9
`define ADCSTC_UNITS         2
// Register byte addresses
`define ADCSTC_OFS_CTRL      8'h00
`define ADCSTC_OFS_TRGEN     8'h04
`define ADCSTC_OFS_SWSTART   8'h08
`define ADCSTC_OFS_STOP      8'h0c
`define ADCSTC_OFS_IRQEN     8'h10
`define ADCSTC_OFS_FLAGS     8'h14
`define ADCSTC_OFS_LIMFLAG   8'h18
`define ADCSTC_OFS_BUSY      8'h1c
`define ADCSTC_OFS_DLY_BASE  8'h20
`define ADCSTC_OFS_GCFG_BASE 8'h40
`define ADCSTC_OFS_GTMR_BASE 8'h80
// Trigger enable bits
`define ADCSTC_TEN_EVENT     0
`define ADCSTC_TEN_TIMER     1
`define ADCSTC_TEN_PIN_A     2
`define ADCSTC_TEN_PIN_B     3
// Group config fields
`define ADCSTC_GC_MODE_LSB   0
`define ADCSTC_GC_UNIT       2
`define ADCSTC_GC_NCH_LSB    3
`define ADCSTC_GC_EVT_LSB    6
`define ADCSTC_GC_PIN_LSB    12
// Flag vector positions
`define ADCSTC_FL_SCAN_LSB   0
`define ADCSTC_FL_ERR_LSB    9
`define ADCSTC_FL_CAL_LSB    11
`define ADCSTC_FL_OVF_LSB    13
`define ADCSTC_FL_CMP_LSB    15
`define ADCSTC_FL_CCMP_LSB   19
`define ADCSTC_FL_LIM        21
`define ADCSTC_FL_W          22
// Reset values
`define ADCSTC_RST_CTRL      4'h0
`define ADCSTC_RST_TRGEN     4'h0
`define ADCSTC_RST_GCFG      14'h0000
// Timing: converter clock is system clock divided by this count
`define ADCSTC_CONV_CLK_DIV  2
// Least trigger spacing in background mode, converter clock cycles
`define ADCSTC_BG_GAP        9'h008

`endif

// file: shared/adcstc_pkg.sv
// Types of the scan/trigger/flag block.
// Constants live in adcstc_defines.svh.
package adcstc_pkg;

	// Scan mode held in each group's config
	typedef enum logic [1:0] {
		ADCSTC_SINGLE,
		ADCSTC_CONT,
		ADCSTC_BACKGROUND
	} adcstc_mode_t;

	// Conversion method per unit
	typedef enum logic [1:0] {
		ADCSTC_SAR,
		ADCSTC_OVERSAMPLE,
		ADCSTC_HYBRID
	} adcstc_method_t;

	// Scan engine state per unit
	typedef enum logic [1:0] {
		ADCSTC_IDLE,
		ADCSTC_ISSUE,
		ADCSTC_WAIT
	} adcstc_state_t;

	// One conversion request to the converter core
	typedef struct packed {
		logic       valid;
		logic [3:0] group;
		logic [2:0] chan;
	} adcstc_conv_t;

endpackage : adcstc_pkg

// file: verilog/adcstc_top.sv
// Scan sequencing, start-trigger selection and interrupt flags for a two-unit converter.
// Assumes the converter core takes one request per unit and pulses CONV_DONE when finished.
//
// How it works
// - Background scan accepted only with hybrid method
// - Simultaneous starts: lowest group number wins
// - Channels converted in ascending virtual order
// - Single scan: one pass per trigger
// - Continuous scan repeats until stopped
// - Background scan starts at first trigger
// - Background publishes results only on retrigger
// - Peripheral start needs selection and enable
// - Delay postpones start by converter clocks
// - Software starts are never delayed
// - Six event-link selection bits per group
// - Twenty timer selection bits per group
// - External start pins are active low
// - Unit error sets flag and interrupt
// - Calibration done sets flag and interrupt
// - Scan end flags; groups 5-8 share interrupt
// - One limiter interrupt, group flags record source
// - Overflow per unit sets flag and interrupt
// - Compare tables 0-3 separate interrupts
// - Two composite compare interrupts
// - Background retrigger closer than 8+delay ignored
// - Forced stop raises no scan-end flag
`include "adcstc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module adcstc_top (
	// Clock and reset
	input  wire logic                               SYS_CLK,
	input  wire logic                               RST_B,
	// Register port
	input  wire logic [7:0]                         ADDR,
	input  wire logic [31:0]                        WDATA,
	input  wire logic                               WR,
	input  wire logic                               RD,
	output logic      [31:0]                        RDATA,
	// Start sources
	input  wire logic [5:0]                         EVENT_LINK_START_EVENT,
	input  wire logic [9:0]                         TIMER_CONV_TRIGGER_A,
	input  wire logic [9:0]                         TIMER_CONV_TRIGGER_B,
	input  wire logic                               EXT_START_PIN_A_B,
	input  wire logic                               EXT_START_PIN_B_B,
	// Converter core
	output adcstc_pkg::adcstc_conv_t [1:0]          CONV_REQ,
	input  wire logic [1:0]                         CONV_DONE,
	output logic      [1:0]                         RESULT_PUBLISH,
	// Core status events
	input  wire logic [1:0]                         UNIT_ERROR_EVT,
	input  wire logic [1:0]                         CALIB_DONE_EVT,
	input  wire logic [1:0]                         OVERFLOW_EVT,
	input  wire logic [3:0]                         COMPARE_EVT,
	input  wire logic [1:0]                         COMPOSITE_EVT,
	input  wire logic [8:0]                         LIMITER_CLIP_EVT,
	// Interrupt requests
	output logic      [4:0]                         GROUP_SCAN_END_IRQ,
	output logic                                    UPPER_GROUPS_SCAN_END_IRQ,
	output logic      [1:0]                         UNIT_ERROR_IRQ,
	output logic      [1:0]                         CALIB_DONE_IRQ,
	output logic      [1:0]                         RESULT_OVERFLOW_IRQ,
	output logic      [3:0]                         COMPARE_TABLE_IRQ,
	output logic      [1:0]                         COMPOSITE_COMPARE_IRQ,
	output logic                                    LIMITER_CLIP_IRQ
);

	localparam int NG = `ADCSTC_GROUPS;
	localparam int NU = `ADCSTC_UNITS;

	// Lowest set bit of a group vector, used by both unit arbiters
	function automatic logic [3:0] lowest_group(input logic [8:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = NG - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : lowest_group

	// Software-visible configuration
	logic [3:0]                  ctrl;          // Method per unit, two bits each
	logic [3:0]                  trig_source_enable;
	logic [13:0]                 gcfg  [NG];    // Mode, unit, channel count, selects
	logic [19:0]                 gtmr  [NG];    // Timer trigger selects
	logic [7:0]                  group_trigger_delay [NG];
	logic [`ADCSTC_FL_W-2:0]     flags;         // Sticky flags except limiter summary
	logic [8:0]                  limiter_group_flag;
	logic [`ADCSTC_FL_W-1:0]     irq_en;

	// Decode of the register port
	wire       wr_ctrl  = WR && ADDR == `ADCSTC_OFS_CTRL;
	wire       wr_trgen = WR && ADDR == `ADCSTC_OFS_TRGEN;
	wire       wr_sw    = WR && ADDR == `ADCSTC_OFS_SWSTART;
	wire       wr_stop  = WR && ADDR == `ADCSTC_OFS_STOP;
	wire       wr_irqen = WR && ADDR == `ADCSTC_OFS_IRQEN;
	wire       wr_flags = WR && ADDR == `ADCSTC_OFS_FLAGS;
	wire       wr_lim   = WR && ADDR == `ADCSTC_OFS_LIMFLAG;
	wire [8:0] sw_start = wr_sw ? WDATA[8:0] : 9'h000;
	wire [1:0] stop_req = wr_stop ? WDATA[1:0] : 2'h0;

	// Converter clock enable; delays and spacing count in its cycles
	logic       div_cnt;
	wire        conv_tick = div_cnt == 1'(`ADCSTC_CONV_CLK_DIV - 1);
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_cnt <= 1'b0;
		end else begin
			div_cnt <= conv_tick ? 1'b0 : div_cnt + 1'b1;
		end
	end

	// Pin synchronisers; the first stage feeds only the second
	logic [1:0] pin_s1;
	logic [1:0] pin_s2;
	logic [1:0] pin_s3;          // Previous level for edge finding
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_s1 <= 2'h3;
			pin_s2 <= 2'h3;
			pin_s3 <= 2'h3;
		end else begin
			pin_s1 <= {EXT_START_PIN_B_B, EXT_START_PIN_A_B};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end
	// A level going low asks for a start; a pin held low asks only once
	wire [1:0] pin_fall = pin_s3 & ~pin_s2;
	// Enabling a pin already low gives no edge, so a stuck-low pin starts nothing
	wire [1:0] pin_hit  = pin_fall & trig_source_enable[3:2];

	// Per-group start requests after source selection and delay
	logic [8:0] dly_pend;
	logic [7:0] dly_cnt [NG];
	logic [8:0] hw_hit;
	logic [8:0] dly_done;
	logic [8:0] start_req;
	for (genvar g = 0; g < NG; g++) begin : g_grp
		wire ev_hit  = trig_source_enable[`ADCSTC_TEN_EVENT]
			&& |(gcfg[g][`ADCSTC_GC_EVT_LSB +: 6] & EVENT_LINK_START_EVENT);
		wire tm_hit  = trig_source_enable[`ADCSTC_TEN_TIMER]
			&& |(gtmr[g] & {TIMER_CONV_TRIGGER_B, TIMER_CONV_TRIGGER_A});
		wire pn_hit  = |(gcfg[g][`ADCSTC_GC_PIN_LSB +: 2] & pin_hit);
		assign hw_hit[g]    = ev_hit || tm_hit || pn_hit;
		assign dly_done[g]  = dly_pend[g] && conv_tick && dly_cnt[g] == 8'h01;
		// Zero delay starts at once; otherwise wait delay converter clocks
		assign start_req[g] = sw_start[g] || dly_done[g]
			|| (hw_hit[g] && group_trigger_delay[g] == 8'h00);

		// Delay counter; a new trigger while waiting reloads it
		always_ff @(posedge SYS_CLK or negedge RST_B) begin
			if (!RST_B) begin
				dly_pend[g] <= 1'b0;
				dly_cnt[g]  <= 8'h00;
			end else if (hw_hit[g] && group_trigger_delay[g] != 8'h00) begin
				dly_pend[g] <= 1'b1;
				dly_cnt[g]  <= group_trigger_delay[g];
			end else if (dly_pend[g] && conv_tick) begin
				dly_pend[g] <= dly_cnt[g] != 8'h01;
				dly_cnt[g]  <= dly_cnt[g] - 8'h01;
			end
		end
	end

	// Scan engines, one per converter unit
	adcstc_pkg::adcstc_state_t state [NU];
	logic [3:0] act_grp  [NU];
	logic [2:0] chan     [NU];
	logic [8:0] gap_cnt  [NU];
	logic [1:0] pub_pend;
	logic [8:0] scan_end_set [NU];
	logic [1:0] retrig_ok;
	logic [1:0] busy;

	for (genvar u = 0; u < NU; u++) begin : g_unit
		logic [8:0] cand;
		for (genvar g = 0; g < NG; g++) begin : g_cand
			wire is_bg = adcstc_pkg::adcstc_mode_t'(gcfg[g][1:0]) == adcstc_pkg::ADCSTC_BACKGROUND;
			wire hyb   = adcstc_pkg::adcstc_method_t'(ctrl[2*u +: 2]) == adcstc_pkg::ADCSTC_HYBRID;
			assign cand[g] = start_req[g] && gcfg[g][`ADCSTC_GC_UNIT] == 1'(u)
				&& (!is_bg || hyb);
		end
		wire [3:0] win     = lowest_group(cand);
		wire [1:0] a_mode  = gcfg[act_grp[u]][1:0];
		wire       bg_mode = adcstc_pkg::adcstc_mode_t'(a_mode) == adcstc_pkg::ADCSTC_BACKGROUND;
		wire [2:0] last_ch = gcfg[act_grp[u]][`ADCSTC_GC_NCH_LSB +: 3];
		wire       done    = state[u] == adcstc_pkg::ADCSTC_WAIT && CONV_DONE[u];
		wire       end_scan = done && chan[u] == last_ch;
		wire [8:0] need_gap = `ADCSTC_BG_GAP + {1'b0, group_trigger_delay[act_grp[u]]};
		assign busy[u]      = state[u] != adcstc_pkg::ADCSTC_IDLE;
		// A retrigger of the running background group, spaced far enough
		assign retrig_ok[u] = busy[u] && bg_mode && cand[act_grp[u]]
			&& gap_cnt[u] >= need_gap;
		assign scan_end_set[u] = (end_scan && !stop_req[u])
			? 9'(9'h001 << act_grp[u]) : 9'h000;

		// Sequencer: idle, issue one channel, wait for its end
		always_ff @(posedge SYS_CLK or negedge RST_B) begin
			if (!RST_B) begin
				state[u]   <= adcstc_pkg::ADCSTC_IDLE;
				act_grp[u] <= 4'h0;
				chan[u]    <= 3'h0;
			end else if (stop_req[u]) begin
				state[u]   <= adcstc_pkg::ADCSTC_IDLE;
			end else begin
				unique case (state[u])
					adcstc_pkg::ADCSTC_IDLE: begin
						if (|cand) begin
							state[u]   <= adcstc_pkg::ADCSTC_ISSUE;
							act_grp[u] <= win;
							chan[u]    <= 3'h0;
						end
					end
					adcstc_pkg::ADCSTC_ISSUE: begin
						state[u] <= adcstc_pkg::ADCSTC_WAIT;
					end
					adcstc_pkg::ADCSTC_WAIT: begin
						if (end_scan) begin
							// Single stops; the repeating modes go round again
							state[u] <= (adcstc_pkg::adcstc_mode_t'(a_mode) == adcstc_pkg::ADCSTC_SINGLE)
								? adcstc_pkg::ADCSTC_IDLE : adcstc_pkg::ADCSTC_ISSUE;
							chan[u]  <= 3'h0;
						end else if (done) begin
							state[u] <= adcstc_pkg::ADCSTC_ISSUE;
							chan[u]  <= chan[u] + 3'h1;
						end
					end
				endcase
			end
		end

		// Background publishing window and trigger spacing counter
		always_ff @(posedge SYS_CLK or negedge RST_B) begin
			if (!RST_B) begin
				pub_pend[u]       <= 1'b0;
				gap_cnt[u]        <= 9'h000;
				RESULT_PUBLISH[u] <= 1'b0;
				CONV_REQ[u]       <= '0;
			end else begin
				if (!busy[u] || retrig_ok[u]) begin
					gap_cnt[u] <= 9'h000;
				end else if (conv_tick && gap_cnt[u] != 9'h1ff) begin
					gap_cnt[u] <= gap_cnt[u] + 9'h001;
				end
				// Publish window opens on retrigger and closes when the scan in progress ends
				if (retrig_ok[u]) begin
					pub_pend[u] <= 1'b1;
				end else if (end_scan || !busy[u]) begin
					pub_pend[u] <= 1'b0;
				end
				RESULT_PUBLISH[u] <= done && (!bg_mode || pub_pend[u]);
				CONV_REQ[u].valid <= state[u] == adcstc_pkg::ADCSTC_ISSUE && !stop_req[u];
				CONV_REQ[u].group <= act_grp[u];
				CONV_REQ[u].chan  <= chan[u];
			end
		end
	end

	// Sticky flags: hardware set wins over software clear
	wire [20:0] flag_set = {COMPOSITE_EVT, COMPARE_EVT, OVERFLOW_EVT, CALIB_DONE_EVT,
		UNIT_ERROR_EVT, scan_end_set[0] | scan_end_set[1]};
	wire [20:0] flag_clr = wr_flags ? WDATA[20:0] : 21'h000000;
	wire [8:0]  lim_clr  = wr_lim ? WDATA[8:0] : 9'h000;
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			flags              <= '0;
			limiter_group_flag <= 9'h000;
		end else begin
			flags              <= (flags & ~flag_clr) | flag_set;
			limiter_group_flag <= (limiter_group_flag & ~lim_clr) | LIMITER_CLIP_EVT;
		end
	end

	// Interrupt requests stand while flag and enable are both set
	wire [21:0] irq_vec = {|limiter_group_flag, flags} & irq_en;
	assign GROUP_SCAN_END_IRQ        = irq_vec[4:0];
	assign UPPER_GROUPS_SCAN_END_IRQ = |irq_vec[8:5];
	assign UNIT_ERROR_IRQ            = irq_vec[`ADCSTC_FL_ERR_LSB +: 2];
	assign CALIB_DONE_IRQ            = irq_vec[`ADCSTC_FL_CAL_LSB +: 2];
	assign RESULT_OVERFLOW_IRQ       = irq_vec[`ADCSTC_FL_OVF_LSB +: 2];
	assign COMPARE_TABLE_IRQ         = irq_vec[`ADCSTC_FL_CMP_LSB +: 4];
	assign COMPOSITE_COMPARE_IRQ     = irq_vec[`ADCSTC_FL_CCMP_LSB +: 2];
	assign LIMITER_CLIP_IRQ          = irq_vec[`ADCSTC_FL_LIM];

	// Configuration writes
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl               <= `ADCSTC_RST_CTRL;
			trig_source_enable <= `ADCSTC_RST_TRGEN;
			irq_en             <= '0;
			for (int g = 0; g < NG; g++) begin
				gcfg[g]                <= `ADCSTC_RST_GCFG;
				gtmr[g]                <= 20'h00000;
				group_trigger_delay[g] <= 8'h00;
			end
		end else begin
			if (wr_ctrl)  ctrl               <= WDATA[3:0];
			if (wr_trgen) trig_source_enable <= WDATA[3:0];
			if (wr_irqen) irq_en             <= WDATA[`ADCSTC_FL_W-1:0];
			for (int g = 0; g < NG; g++) begin
				if (WR && ADDR == `ADCSTC_OFS_GCFG_BASE + 8'(4 * g)) gcfg[g] <= WDATA[13:0];
				if (WR && ADDR == `ADCSTC_OFS_GTMR_BASE + 8'(4 * g)) gtmr[g] <= WDATA[19:0];
				// Two groups share one delay word, low byte for the even group
				if (WR && ADDR == `ADCSTC_OFS_DLY_BASE + 8'(4 * (g / 2)))
					group_trigger_delay[g] <= WDATA[8 * (g % 2) +: 8];
			end
		end
	end

	// Read selection; unmapped addresses read zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (ADDR)
			`ADCSTC_OFS_CTRL:    rd_mux = {28'h0, ctrl};
			`ADCSTC_OFS_TRGEN:   rd_mux = {28'h0, trig_source_enable};
			`ADCSTC_OFS_IRQEN:   rd_mux = {10'h0, irq_en};
			`ADCSTC_OFS_FLAGS:   rd_mux = {10'h0, |limiter_group_flag, flags};
			`ADCSTC_OFS_LIMFLAG: rd_mux = {23'h0, limiter_group_flag};
			`ADCSTC_OFS_BUSY:    rd_mux = {22'h0, act_grp[1], act_grp[0], busy};
			default: begin
				for (int g = 0; g < NG; g++) begin
					if (ADDR == `ADCSTC_OFS_GCFG_BASE + 8'(4 * g)) rd_mux = {18'h0, gcfg[g]};
					if (ADDR == `ADCSTC_OFS_GTMR_BASE + 8'(4 * g)) rd_mux = {12'h0, gtmr[g]};
				end
				for (int i = 0; i < 5; i++) begin
					if (ADDR == `ADCSTC_OFS_DLY_BASE + 8'(4 * i))
						rd_mux = {16'h0, (2 * i + 1 < NG) ? group_trigger_delay[(2 * i + 1) % NG]
							: 8'h00, group_trigger_delay[2 * i]};
				end
			end
		endcase
	end

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= 32'h00000000;
		end else begin
			RDATA <= RD ? rd_mux : 32'h00000000;
		end
	end

	// Checks on the scan engines and flags
	a_stop_no_end: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		stop_req[0] |=> !busy[0] && !$rose(flags[act_grp[0]]))
		else $error("scan end flagged after forced stop");
	a_single_idle: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		g_unit[0].end_scan && !stop_req[0] && g_unit[0].a_mode == 2'h0 |=> !busy[0])
		else $error("single scan did not stop");
	a_cont_again: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		g_unit[1].end_scan && !stop_req[1] && g_unit[1].a_mode == 2'h1
		|=> busy[1] && chan[1] == 3'h0 ##1 (CONV_REQ[1].valid || $past(stop_req[1])))
		else $error("continuous scan did not restart at channel zero");
	a_chan_ascend: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		g_unit[1].done && !g_unit[1].end_scan && !stop_req[1] |=> chan[1] == $past(chan[1]) + 3'h1)
		else $error("channel order not ascending");
	a_lowest_wins: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		!busy[0] && g_unit[0].cand[1] && g_unit[0].cand[2] && !stop_req[0] |=> act_grp[0] == 4'h1)
		else $error("lower group lost arbitration");
	a_sw_nodelay: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		sw_start[1] && g_unit[0].cand[1] && !g_unit[0].cand[0] && !busy[0] && !stop_req[0]
		|=> busy[0] && act_grp[0] == 4'h1)
		else $error("software start was delayed");
	a_bg_publish: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		g_unit[0].done && g_unit[0].bg_mode && !pub_pend[0] |=> !RESULT_PUBLISH[0])
		else $error("background result published without retrigger");
	a_flag_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		flags[9] && !(wr_flags && WDATA[9]) |=> flags[9] && (UNIT_ERROR_IRQ[0] == irq_en[9]))
		else $error("error flag lost or irq mismatch");
	a_gap_ignore: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		$rose(pub_pend[0]) |-> $past(gap_cnt[0]) >= `ADCSTC_BG_GAP)
		else $error("background retrigger taken too soon");

endmodule : adcstc_top

`default_nettype wire

// file: dv/adcstc_core_model.sv
// Behavioural converter core: answers each scan request with one done pulse.
// Assumes one outstanding request per unit, as the scan engine issues them.
`timescale 1ns/1ps
`default_nettype none

module adcstc_core_model (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	// Scan engine side
	input  wire adcstc_pkg::adcstc_conv_t [1:0] req,
	output logic                          [1:0] done
);
	logic [2:0] cnt [2]; // Cycles left per unit
	logic [1:0] slow;    // Alternates prompt and slow answers

	// Count down and pulse done once per request; slow answers stress the wait path
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '{default: 3'h0};
			done <= 2'h0;
			slow <= 2'h0;
		end else begin
			for (int u = 0; u < 2; u++) begin
				done[u] <= (cnt[u] == 3'h1);
				if (req[u].valid) begin
					cnt[u] <= slow[u] ? 3'h5 : 3'h1;
					slow[u] <= ~slow[u];
				end else if (cnt[u] != 3'h0) begin
					cnt[u] <= cnt[u] - 3'h1;
				end
			end
		end
	end
endmodule : adcstc_core_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the scan, trigger and flag block.
// Assumes adcstc_core_model answers every request of the scan engine.
`include "adcstc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        clk, rst_b, wr_s, rd_s, pin_a, pin_b, lirq; // Clock, reset, strobes, pins
	logic [19:0] tmr;                                 // Timer triggers, B above A
	logic [7:0]  addr;                                // Register address
	logic [31:0] wdata, rdata, rdat;                  // Bus data, last read
	logic [5:0]  evt, sirq;                           // Event starts, scan-end irqs
	logic [11:0] stat, xirq;                          // Status events and irqs
	logic [8:0]  lim;                                 // Limiter clip per group
	logic [1:0]  done, pub;                           // Core done, publish
	adcstc_pkg::adcstc_conv_t [1:0] req;              // Requests to the core
	logic [7:0]  q[$];                                // Logged {unit,group,chan}
	int          bad_count, compares, seed, n, g, u, k, npub;

	adcstc_top DUT (
		.SYS_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.RDATA(rdata), .EVENT_LINK_START_EVENT(evt), .TIMER_CONV_TRIGGER_A(tmr[9:0]),
		.TIMER_CONV_TRIGGER_B(tmr[19:10]), .EXT_START_PIN_A_B(pin_a), .EXT_START_PIN_B_B(pin_b),
		.CONV_REQ(req), .CONV_DONE(done), .RESULT_PUBLISH(pub),
		.UNIT_ERROR_EVT(stat[1:0]), .CALIB_DONE_EVT(stat[3:2]), .OVERFLOW_EVT(stat[5:4]),
		.COMPARE_EVT(stat[9:6]), .COMPOSITE_EVT(stat[11:10]), .LIMITER_CLIP_EVT(lim),
		.GROUP_SCAN_END_IRQ(sirq[4:0]), .UPPER_GROUPS_SCAN_END_IRQ(sirq[5]),
		.UNIT_ERROR_IRQ(xirq[1:0]), .CALIB_DONE_IRQ(xirq[3:2]), .RESULT_OVERFLOW_IRQ(xirq[5:4]),
		.COMPARE_TABLE_IRQ(xirq[9:6]), .COMPOSITE_COMPARE_IRQ(xirq[11:10]), .LIMITER_CLIP_IRQ(lirq)
	);
	adcstc_core_model core (.clk(clk), .rst_b(rst_b), .req(req), .done(done));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Log every request the engine issues
	always @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (req[i].valid === 1'b1) q.push_back({i[0], req[i].group, req[i].chan});
			if (pub[i] === 1'b1) npub++;
		end
	end

	// Group config word
	function automatic logic [31:0] gcfg(input int m, un, nc, ev, pn);
		return m | (un << `ADCSTC_GC_UNIT) | ((nc - 1) << 3) | (ev << 6) | (pn << 12);
	endfunction : gcfg
	// Scan-end irq vector: groups 5 to 8 share the top bit
	function automatic logic [5:0] sirq_exp(input int grp);
		return (grp < 5) ? 6'h01 << grp : 6'h20;
	endfunction : sirq_exp

	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input int a, input logic [31:0] v);
		@(posedge clk);
		addr <= 8'(a);
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input int a);
		@(posedge clk);
		addr <= 8'(a);
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 rdat = rdata;
	endtask : rd
	// Bounded wait for c logged requests
	task automatic wait_q(input int c);
		for (int i = 0; i < 300 && q.size() < c; i++) @(posedge clk);
		if (q.size() < c) begin
			bad_count++;
			$display("MISMATCH request wait expected %0d seen %0d", c, q.size());
			close_out();
		end
	endtask : wait_q
	task automatic pulse_evt(input logic [5:0] v);
		evt <= v;
		@(posedge clk);
		evt <= 6'h00;
	endtask : pulse_evt

	initial begin
		seed = 32'h715bf795;
		bad_count = 0;
		compares = 0;
		{wr_s, rd_s, addr, wdata, evt, stat, lim, tmr} = '0;
		{pin_a, pin_b} = 2'h3;
		rst_b = 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values and an unmapped read
		rd(`ADCSTC_OFS_TRGEN);
		chk("trgen", `ADCSTC_RST_TRGEN, rdat);
		rd(`ADCSTC_OFS_GCFG_BASE);
		chk("gcfg", `ADCSTC_RST_GCFG, rdat);
		rd(8'hfc);
		chk("unmapped", 0, rdat);
		$display("reset values done");
		// Random single scans by software
		wr(`ADCSTC_OFS_IRQEN, 32'h003fffff);
		for (k = 0; k < 6; k++) begin
			g = (k == 0) ? 8 : $unsigned($random(seed)) % 9;
			u = $random(seed) & 1;
			n = (k == 1) ? 8 : ($unsigned($random(seed)) % 8) + 1;
			q.delete();
			npub = 0;
			wr(`ADCSTC_OFS_GCFG_BASE + 4 * g, gcfg(0, u, n, 0, 0));
			wr(`ADCSTC_OFS_SWSTART, 1 << g);
			wait_q(n);
			repeat (14) @(posedge clk);
			chk("req count", n, q.size());
			chk("pub count", n, npub);
			for (int c = 0; c < n; c++) chk("req", {u[0], g[3:0], c[2:0]}, q[c]);
			rd(`ADCSTC_OFS_FLAGS);
			chk("scan flag", 1 << g, rdat);
			chk("scan irq", sirq_exp(g), sirq);
			wr(`ADCSTC_OFS_FLAGS, 32'h001fffff);
			rd(`ADCSTC_OFS_FLAGS);
			chk("flag clear", 0, rdat);
			$display("single scan group %0d unit %0d done", g, u);
		end
		// Two groups of one unit started together
		q.delete();
		wr(`ADCSTC_OFS_GCFG_BASE + 4, gcfg(0, 0, 2, 0, 0));
		wr(`ADCSTC_OFS_GCFG_BASE + 8, gcfg(0, 0, 2, 0, 0));
		wr(`ADCSTC_OFS_DLY_BASE, 32'h0000ff00);
		wr(`ADCSTC_OFS_SWSTART, 32'h6);
		wait_q(2);
		repeat (14) @(posedge clk);
		chk("prio count", 2, q.size());
		chk("prio req", {1'b0, 4'h1, 3'h1}, q[1]);
		rd(`ADCSTC_OFS_FLAGS);
		chk("prio flag", 32'h2, rdat);
		$display("priority done");
		// Peripheral starts need select and enable
		q.delete();
		wr(`ADCSTC_OFS_GCFG_BASE + 12, gcfg(0, 0, 1, 1, 1));
		pulse_evt(6'h01);
		pin_a <= 1'b0;
		repeat (12) @(posedge clk);
		pin_a <= 1'b1;
		chk("no start", 0, q.size());
		wr(`ADCSTC_OFS_TRGEN, 32'h1);
		pulse_evt(6'h01);
		wait_q(1);
		chk("event start", {1'b0, 4'h3, 3'h0}, q[0]);
		repeat (8) @(posedge clk);
		q.delete();
		wr(`ADCSTC_OFS_TRGEN, 32'h4);
		pin_a <= 1'b0;
		wait_q(1);
		pin_a <= 1'b1;
		chk("pin start", {1'b0, 4'h3, 3'h0}, q[0]);
		// Random timer output through a delay of four converter clocks
		repeat (8) @(posedge clk);
		q.delete();
		k = $unsigned($random(seed)) % 20;
		wr(`ADCSTC_OFS_GTMR_BASE + 12, 32'h1 << k);
		wr(`ADCSTC_OFS_DLY_BASE + 4, 32'h00000400);
		wr(`ADCSTC_OFS_TRGEN, 32'h2);
		tmr <= 20'h00001 << k;
		@(posedge clk);
		tmr <= 20'h00000;
		repeat (6) @(posedge clk);
		chk("delay hold", 0, q.size());
		wait_q(1);
		chk("timer start", {1'b0, 4'h3, 3'h0}, q[0]);
		// Second external pin
		repeat (8) @(posedge clk);
		q.delete();
		wr(`ADCSTC_OFS_GCFG_BASE + 12, gcfg(0, 0, 1, 0, 2));
		wr(`ADCSTC_OFS_TRGEN, 32'h8);
		pin_b <= 1'b0;
		wait_q(1);
		pin_b <= 1'b1;
		chk("pin b start", {1'b0, 4'h3, 3'h0}, q[0]);
		$display("trigger sources done");
		// Continuous scan then forced stop
		q.delete();
		wr(`ADCSTC_OFS_GCFG_BASE + 16, gcfg(1, 1, 2, 0, 0));
		wr(`ADCSTC_OFS_SWSTART, 32'h10);
		wait_q(5);
		chk("repeat", {1'b1, 4'h4, 3'h0}, q[4]);
		wr(`ADCSTC_OFS_STOP, 32'h2);
		wr(`ADCSTC_OFS_FLAGS, 32'h001fffff);
		q.delete();
		repeat (14) @(posedge clk);
		chk("stopped", 0, q.size());
		rd(`ADCSTC_OFS_FLAGS);
		chk("stop flag", 0, rdat);
		// Background scan needs the hybrid method
		wr(`ADCSTC_OFS_GCFG_BASE + 20, gcfg(2, 0, 2, 0, 0));
		wr(`ADCSTC_OFS_SWSTART, 32'h20);
		repeat (12) @(posedge clk);
		chk("bg refused", 0, q.size());
		wr(`ADCSTC_OFS_CTRL, 32'h2);
		npub = 0;
		wr(`ADCSTC_OFS_SWSTART, 32'h20);
		wr(`ADCSTC_OFS_SWSTART, 32'h20);
		wait_q(3);
		chk("bg start", {1'b0, 4'h5, 3'h0}, q[2]);
		repeat (20) @(posedge clk);
		chk("bg quiet", 0, npub);
		wr(`ADCSTC_OFS_SWSTART, 32'h20);
		repeat (20) @(posedge clk);
		chk("bg publish", 1, npub > 0 && npub < 3);
		wr(`ADCSTC_OFS_STOP, 32'h1);
		repeat (8) @(posedge clk);
		wr(`ADCSTC_OFS_FLAGS, 32'h001fffff);
		$display("stop and background done");
		// Status events set flags and irqs one at a time
		for (k = 0; k < 12; k++) begin
			stat <= 12'h001 << k;
			@(posedge clk);
			stat <= 12'h000;
			rd(`ADCSTC_OFS_FLAGS);
			chk("status flag", 32'h1 << (9 + k), rdat);
			chk("status irq", 12'h001 << k, xirq);
			wr(`ADCSTC_OFS_FLAGS, 32'h1 << (9 + k));
		end
		// Limiter clip on a random group, then masked
		k = $unsigned($random(seed)) % 9;
		lim <= 9'h001 << k;
		@(posedge clk);
		lim <= 9'h000;
		rd(`ADCSTC_OFS_LIMFLAG);
		chk("lim group", 32'h1 << k, rdat);
		chk("lim irq", 1, lirq);
		wr(`ADCSTC_OFS_IRQEN, 0);
		#1 chk("lim masked", 0, lirq);
		wr(`ADCSTC_OFS_LIMFLAG, 32'h1ff);
		rd(`ADCSTC_OFS_FLAGS);
		chk("lim clear", 0, rdat);
		$display("status flags done");
		close_out();
	end
endmodule : testbench
`default_nettype wire
